// ---- rtl/hpi_pkg.sv ----
package hpi_pkg;
    // core clock
    localparam int unsigned CLK_NS = 25;
    // start bit hold time and derived cycle counts (least time, rounded up)
    localparam int unsigned START_BIT_NS = 208;
    localparam int unsigned START_CYC = (START_BIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned BIT_CYC = START_CYC;
    // receive glitch filter length in cycles
    localparam int unsigned RX_FILT_CYC = 3;
    // character layout
    localparam int unsigned CODE_W = 7;
    localparam int unsigned HALF_LO_BITS = 4;
    localparam int unsigned HALF_HI_BITS = 3;
    localparam int unsigned STOP_BITS = 2;
    localparam logic [6:0] RUN_CODE = 7'h41;
    // external register and slot addresses
    localparam logic [15:0] OFS_PANEL_IRQ = 16'h0040;
    localparam logic [15:0] OFS_STEP_SET = 16'h001b;
    localparam logic [15:0] OFS_TX_START = 16'h001e;
    localparam logic [15:0] OFS_STATUS = 16'h0080;
    localparam logic [15:0] OFS_MASK = 16'h0081;
    localparam logic [15:0] OFS_INCODE = 16'h00f6;
    localparam logic [15:0] OFS_STACK_PTR = 16'hfff0;
    localparam logic [15:0] OFS_DATA_SLOT = 16'hfffa;
    localparam logic [15:0] OFS_SAVE_PSW = 16'hfffc;
    localparam logic [15:0] OFS_SAVE_PC = 16'hfffe;
    // vectors and reset values
    localparam logic [15:0] VEC_RTC = 16'h0004;
    localparam logic [15:0] VEC_PANEL = 16'h0006;
    localparam logic [15:0] STACK_INIT = 16'hfff2;
    localparam logic [15:0] STACK_RESET = 16'h0000;
    localparam logic [4:0] MASK_RESET = 5'h00;
    // status word bits
    localparam int unsigned PSW_RUN_BIT = 0;
    localparam int unsigned PSW_STEP_BIT = 1;
    // status buffer bits
    localparam int unsigned ST_RTC = 0;
    localparam int unsigned ST_RX_EDGE = 1;
    localparam int unsigned ST_RX_DONE = 2;
    localparam int unsigned ST_STEP = 3;
    localparam int unsigned ST_TX_DONE = 4;
    localparam int unsigned ST_W = 5;
    // transmit sequencer states
    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_START = 4'b0010,
        TX_DATA = 4'b0100,
        TX_STOP = 4'b1000
    } hpi_tx_state_t;
endpackage : hpi_pkg

// ---- rtl/hpi_tx.sv ----
`timescale 1ns/1ps
module hpi_tx import hpi_pkg::*; #(
    parameter int unsigned START_CYC_P = START_CYC,
    parameter int unsigned BIT_CYC_P = BIT_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // character request
    input wire logic txStart,
    input wire logic [CODE_W-1:0] txCode,
    output logic txBusy,
    output logic txDone,
    // line driver, high means space (start bit)
    output logic serialPin
);
    hpi_tx_state_t state_q, state_d;
    logic [7:0] timer_q, timer_d;
    logic [2:0] bitCnt_q, bitCnt_d;
    logic half_q, half_d;
    logic [CODE_W-1:0] shift_q, shift_d;
    logic pin_q, pin_d;
    logic done_q, done_d;
    logic timerZero;

    assign timerZero = (timer_q == 8'h00);

    // sequencer next state
    always_comb begin
        state_d = state_q;
        timer_d = timerZero ? timer_q : timer_q - 8'h01;
        bitCnt_d = bitCnt_q;
        half_d = half_q;
        shift_d = shift_q;
        pin_d = pin_q;
        done_d = 1'b0;
        case (state_q)
            TX_IDLE: begin
                pin_d = 1'b0;
                if (txStart) begin
                    state_d = TX_START;
                    pin_d = 1'b1;
                    shift_d = txCode;
                    timer_d = 8'(START_CYC_P - 1);
                end
            end
            TX_START: begin
                if (timerZero) begin
                    state_d = TX_DATA;
                    half_d = 1'b0;
                    bitCnt_d = 3'(HALF_LO_BITS - 1);
                    timer_d = 8'(BIT_CYC_P - 1);
                    pin_d = ~shift_q[0];
                    shift_d = shift_q >> 1;
                end
            end
            TX_DATA: begin
                if (timerZero) begin
                    timer_d = 8'(BIT_CYC_P - 1);
                    if (bitCnt_q != 3'h0) begin
                        bitCnt_d = bitCnt_q - 3'h1;
                        pin_d = ~shift_q[0];
                        shift_d = shift_q >> 1;
                    end else if (!half_q) begin
                        half_d = 1'b1;
                        bitCnt_d = 3'(HALF_HI_BITS - 1);
                        pin_d = ~shift_q[0];
                        shift_d = shift_q >> 1;
                    end else begin
                        state_d = TX_STOP;
                        bitCnt_d = 3'(STOP_BITS - 1);
                        pin_d = 1'b0;
                    end
                end
            end
            TX_STOP: begin
                pin_d = 1'b0;
                if (timerZero) begin
                    timer_d = 8'(BIT_CYC_P - 1);
                    if (bitCnt_q == 3'h0) begin
                        state_d = TX_IDLE;
                        done_d = 1'b1;
                    end else begin
                        bitCnt_d = bitCnt_q - 3'h1;
                    end
                end
            end
            default: begin
                state_d = TX_IDLE;
                pin_d = 1'b0;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= TX_IDLE;
            timer_q <= 8'h00;
            bitCnt_q <= 3'h0;
            half_q <= 1'b0;
            shift_q <= '0;
            pin_q <= 1'b0;
            done_q <= 1'b0;
            txBusy <= 1'b0;
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
            bitCnt_q <= bitCnt_d;
            half_q <= half_d;
            shift_q <= shift_d;
            pin_q <= pin_d;
            done_q <= done_d;
            txBusy <= (state_d != TX_IDLE);
        end
    end

    assign serialPin = pin_q;
    assign txDone = done_q;

    // checks on the line framing
    a_start_hold: assert property (@(posedge core_clk) disable iff (!resetn)
        (txStart && state_q == TX_IDLE) |=> serialPin [*8] ##1 serialPin)
        else $error("start bit not held for the full start time");
    a_idle_rest: assert property (@(posedge core_clk) disable iff (!resetn)
        (state_q == TX_IDLE && !txStart) |=> !serialPin)
        else $error("line not at stop level while idle");
    a_frame_len: assert property (@(posedge core_clk) disable iff (!resetn)
        (txStart && state_q == TX_IDLE) |-> ##91 txDone)
        else $error("character frame length wrong");
    c_frame_done: cover property (@(posedge core_clk) disable iff (!resetn)
        txDone);
endmodule : hpi_tx

// ---- rtl/hpi_panel_if.sv ----
// What this block does
// - real-time-clock falling edge raises level-2 interrupt, vector 0004, when enabled
// - write to 0040 drives panel interrupt low, vector 0006 when enabled
// - write to 001B latches the step flag on the next clock
// - with step flag set, one instruction completes, next fetch traps
// - step trap saves status word with run cleared, step set; sends PC
// - filtered inverted message leading edge raises firmware interrupt; 0080 reads status
// - received message data stored in data slot before completion is flagged
// - lock level sampled only after power-on and after power failure
// - characters framed start 1, inverted data LSB first, two stop 0 bits
// - write to 001E begins the start bit, pin driven high
// - start bit held 9 cycles (225 ns, at least 208 ns) before data bits follow
// - low data half-character, then upper half, then two stop bits
// - every transmission loads the stack pointer with FFF2
// - entering run mode sends the run code to the panel
`timescale 1ns/1ps
module hpi_panel_if import hpi_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // register port
    input wire logic [15:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata,
    // processor side
    input wire logic global_irq_enable,
    input wire logic higherInService,
    input wire logic instrEnd,
    input wire logic fetch_phase_n,
    input wire logic runMode,
    input wire logic powerFail,
    input wire logic [15:0] pswIn,
    input wire logic [15:0] pcIn,
    output logic level2_irq_n,
    output logic panel_irq_n,
    output logic vectorTake,
    output logic [15:0] vectorAddr,
    output logic stepFlag,
    output logic step_flag_n,
    output logic step_trap_n,
    output logic firmware_irq,
    // panel side
    input wire logic rtc_enable_in,
    input wire logic realtime_tick_n,
    input wire logic panel_to_cpu_serial,
    input wire logic panelLock,
    output logic cpu_to_panel_serial
);
    // cpu-side state
    logic tickPrev_q, tickPrev_d, rtcPend_q, rtcPend_d, panPend_q, panPend_d;
    logic take_q, take_d, stepFlag_q, stepFlag_d, stepArm_q, stepArm_d;
    logic fetchPrev_q, fetchPrev_d, trapN_q, trapN_d;
    logic [15:0] vec_q, vec_d, savedPsw_q, savedPsw_d, savedPc_q, savedPc_d;
    logic [15:0] stackPtr_q, stackPtr_d, rdata_q, rdata_d;
    logic [ST_W-1:0] status_q, status_d, mask_q, mask_d;
    logic irq_q, irq_d, initDone_q, initDone_d, lock_q, lock_d;
    logic runPrev_q, runPrev_d, runPend_q, runPend_d, pcPend_q, pcPend_d;
    logic [ST_W-1:0] events;
    logic wrHit, rtcFall, fetchRise, fetchFall, txStart, txBusy, txDone;
    logic [CODE_W-1:0] txCode;
    // receive-side state
    logic rxLevel_q, rxLevel_d, rxPrev_q, rxPrev_d, rxBusy_q, rxBusy_d;
    logic [1:0] filtCnt_q, filtCnt_d;
    logic [7:0] rxTimer_q, rxTimer_d;
    logic [2:0] rxBits_q, rxBits_d;
    logic [CODE_W-1:0] rxShift_q, rxShift_d;
    logic rxStore_q, rxStore_d, rxDoneEv_q, rxDoneEv_d;
    logic [15:0] dataSlot_q, dataSlot_d;
    logic rxEdge;

    assign wrHit = regWr;
    assign rtcFall = tickPrev_q && !realtime_tick_n && rtc_enable_in;
    assign fetchRise = !fetchPrev_q && fetch_phase_n;
    assign fetchFall = fetchPrev_q && !fetch_phase_n;
    assign rxEdge = rxPrev_q && !rxLevel_q;

    // transmit request arbitration: software write first, then queued sends
    always_comb begin
        txStart = 1'b0;
        txCode = regWdata[CODE_W-1:0];
        if (wrHit && regAddr == OFS_TX_START && !txBusy) begin
            txStart = 1'b1;
        end else if (!txBusy && pcPend_q) begin
            txStart = 1'b1;
            txCode = savedPc_q[CODE_W-1:0];
        end else if (!txBusy && runPend_q) begin
            txStart = 1'b1;
            txCode = RUN_CODE;
        end
    end

    // sticky event sources for the status buffer
    always_comb begin
        events = '0;
        events[ST_RTC] = rtcFall;
        events[ST_RX_EDGE] = rxEdge;
        events[ST_RX_DONE] = rxDoneEv_q;
        events[ST_STEP] = !trapN_d;
        events[ST_TX_DONE] = txDone;
    end

    // processor-side next values
    always_comb begin
        tickPrev_d = realtime_tick_n;
        fetchPrev_d = fetch_phase_n;
        runPrev_d = runMode;
        rtcPend_d = rtcPend_q || rtcFall;
        panPend_d = panPend_q;
        take_d = 1'b0;
        vec_d = vec_q;
        stepFlag_d = stepFlag_q;
        stepArm_d = stepArm_q;
        trapN_d = 1'b1;
        savedPsw_d = savedPsw_q;
        savedPc_d = savedPc_q;
        stackPtr_d = txStart ? STACK_INIT : stackPtr_q;
        mask_d = mask_q;
        status_d = status_q;
        initDone_d = 1'b1;
        lock_d = lock_q;
        runPend_d = runPend_q || (runMode && !runPrev_q);
        pcPend_d = pcPend_q;
        rdata_d = 16'h0000;
        if (!initDone_q || powerFail) begin
            lock_d = panelLock;
        end
        if (wrHit && regAddr == OFS_PANEL_IRQ) begin
            panPend_d = 1'b1;
        end
        if (wrHit && regAddr == OFS_STEP_SET) begin
            stepFlag_d = 1'b1;
        end
        if (wrHit && regAddr == OFS_MASK) begin
            mask_d = regWdata[ST_W-1:0];
        end
        if (wrHit && regAddr == OFS_STATUS) begin
            status_d = status_q & ~regWdata[ST_W-1:0];
        end
        status_d = status_d | events; // set wins over clear
        // one instruction completes, the following fetch traps
        if (stepFlag_q && !stepArm_q && fetchRise) begin
            stepArm_d = 1'b1;
        end
        if (stepArm_q && fetchFall) begin
            trapN_d = 1'b0;
            stepFlag_d = wrHit && regAddr == OFS_STEP_SET;
            stepArm_d = 1'b0;
            savedPsw_d = pswIn;
            savedPsw_d[PSW_RUN_BIT] = 1'b0;
            savedPsw_d[PSW_STEP_BIT] = 1'b1;
            savedPc_d = pcIn;
            pcPend_d = 1'b1;
        end
        if (txStart) begin
            if (pcPend_q && !(wrHit && regAddr == OFS_TX_START)) begin
                pcPend_d = stepArm_q && fetchFall;
            end else if (runPend_q && !(wrHit && regAddr == OFS_TX_START)) begin
                runPend_d = (runMode && !runPrev_q);
            end
        end
        // vectoring when enabled, idle above and instruction finished
        if (global_irq_enable && !higherInService && instrEnd && !take_q) begin
            if (rtcPend_q) begin
                take_d = 1'b1;
                vec_d = VEC_RTC;
                rtcPend_d = rtcFall;
            end else if (panPend_q) begin
                take_d = 1'b1;
                vec_d = VEC_PANEL;
                panPend_d = wrHit && regAddr == OFS_PANEL_IRQ; // new write wins
            end
        end
        irq_d = |(status_d & mask_d);
        if (regRd) begin
            case (regAddr)
                OFS_STATUS: rdata_d = {{(16-ST_W){1'b0}}, status_q};
                OFS_MASK: rdata_d = {{(16-ST_W){1'b0}}, mask_q};
                OFS_INCODE: rdata_d = {15'h0000, lock_q};
                OFS_STACK_PTR: rdata_d = stackPtr_q;
                OFS_DATA_SLOT: rdata_d = dataSlot_q;
                OFS_SAVE_PSW: rdata_d = savedPsw_q;
                OFS_SAVE_PC: rdata_d = savedPc_q;
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    // processor-side registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tickPrev_q <= 1'b1;
            fetchPrev_q <= 1'b1;
            runPrev_q <= 1'b0;
            rtcPend_q <= 1'b0;
            panPend_q <= 1'b0;
            take_q <= 1'b0;
            vec_q <= 16'h0000;
            stepFlag_q <= 1'b0;
            stepArm_q <= 1'b0;
            trapN_q <= 1'b1;
            savedPsw_q <= 16'h0000;
            savedPc_q <= 16'h0000;
            stackPtr_q <= STACK_RESET;
            mask_q <= MASK_RESET;
            status_q <= '0;
            irq_q <= 1'b0;
            initDone_q <= 1'b0;
            lock_q <= 1'b0;
            runPend_q <= 1'b0;
            pcPend_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            tickPrev_q <= tickPrev_d;
            fetchPrev_q <= fetchPrev_d;
            runPrev_q <= runPrev_d;
            rtcPend_q <= rtcPend_d;
            panPend_q <= panPend_d;
            take_q <= take_d;
            vec_q <= vec_d;
            stepFlag_q <= stepFlag_d;
            stepArm_q <= stepArm_d;
            trapN_q <= trapN_d;
            savedPsw_q <= savedPsw_d;
            savedPc_q <= savedPc_d;
            stackPtr_q <= stackPtr_d;
            mask_q <= mask_d;
            status_q <= status_d;
            irq_q <= irq_d;
            initDone_q <= initDone_d;
            lock_q <= lock_d;
            runPend_q <= runPend_d;
            pcPend_q <= pcPend_d;
            rdata_q <= rdata_d;
        end
    end

    // receive filter, edge detect and character shifter
    always_comb begin
        filtCnt_d = 2'h0;
        rxLevel_d = rxLevel_q;
        rxPrev_d = rxLevel_q;
        rxBusy_d = rxBusy_q;
        rxTimer_d = (rxTimer_q == 8'h00) ? rxTimer_q : rxTimer_q - 8'h01;
        rxBits_d = rxBits_q;
        rxShift_d = rxShift_q;
        rxStore_d = 1'b0;
        rxDoneEv_d = rxStore_q;
        dataSlot_d = dataSlot_q;
        if (!panel_to_cpu_serial != rxLevel_q) begin
            filtCnt_d = filtCnt_q + 2'h1;
            if (filtCnt_q == 2'(RX_FILT_CYC - 1)) begin
                rxLevel_d = !panel_to_cpu_serial;
                filtCnt_d = 2'h0;
            end
        end
        if (rxEdge && !rxBusy_q) begin
            rxBusy_d = 1'b1;
            rxTimer_d = 8'(BIT_CYC + BIT_CYC / 2 - 1);
            rxBits_d = 3'(CODE_W - 1);
        end else if (rxBusy_q && rxTimer_q == 8'h00) begin
            rxShift_d = {rxLevel_q, rxShift_q[CODE_W-1:1]};
            rxTimer_d = 8'(BIT_CYC - 1);
            if (rxBits_q == 3'h0) begin
                rxBusy_d = 1'b0;
                rxStore_d = 1'b1;
            end else begin
                rxBits_d = rxBits_q - 3'h1;
            end
        end
        if (rxStore_q) begin
            dataSlot_d = {{(16-CODE_W){1'b0}}, rxShift_q};
        end
    end

    // receive registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            filtCnt_q <= 2'h0;
            rxLevel_q <= 1'b1;
            rxPrev_q <= 1'b1;
            rxBusy_q <= 1'b0;
            rxTimer_q <= 8'h00;
            rxBits_q <= 3'h0;
            rxShift_q <= '0;
            rxStore_q <= 1'b0;
            rxDoneEv_q <= 1'b0;
            dataSlot_q <= 16'h0000;
        end else begin
            filtCnt_q <= filtCnt_d;
            rxLevel_q <= rxLevel_d;
            rxPrev_q <= rxPrev_d;
            rxBusy_q <= rxBusy_d;
            rxTimer_q <= rxTimer_d;
            rxBits_q <= rxBits_d;
            rxShift_q <= rxShift_d;
            rxStore_q <= rxStore_d;
            rxDoneEv_q <= rxDoneEv_d;
            dataSlot_q <= dataSlot_d;
        end
    end

    // character transmitter
    hpi_tx #(.START_CYC_P(START_CYC), .BIT_CYC_P(BIT_CYC)) uTx (
        .core_clk(core_clk),
        .resetn(resetn),
        .txStart(txStart),
        .txCode(txCode),
        .txBusy(txBusy),
        .txDone(txDone),
        .serialPin(cpu_to_panel_serial)
    );

    // outputs straight from flip-flops
    assign regRdata = rdata_q;
    assign level2_irq_n = !rtcPend_q;
    assign panel_irq_n = !panPend_q;
    assign vectorTake = take_q;
    assign vectorAddr = vec_q;
    assign stepFlag = stepFlag_q;
    assign step_flag_n = !stepFlag_q;
    assign step_trap_n = trapN_q;
    assign firmware_irq = irq_q;

    // checks on processor-side behaviour
    a_rtc_raise: assert property (@(posedge core_clk) disable iff (!resetn)
        rtcFall |=> !level2_irq_n)
        else $error("tick edge did not raise level-2 request");
    a_rtc_vector: assert property (@(posedge core_clk) disable iff (!resetn)
        (rtcPend_q && global_irq_enable && !higherInService && instrEnd
        && !take_q) |=> vectorTake && vectorAddr == VEC_RTC)
        else $error("level-2 request not vectored to 0004");
    a_panel_line: assert property (@(posedge core_clk) disable iff (!resetn)
        (regWr && regAddr == OFS_PANEL_IRQ) |=> !panel_irq_n)
        else $error("panel interrupt line not driven low");
    a_step_latch: assert property (@(posedge core_clk) disable iff (!resetn)
        (regWr && regAddr == OFS_STEP_SET) |=> stepFlag && !step_flag_n)
        else $error("step flag not latched after write");
    a_step_trap: assert property (@(posedge core_clk) disable iff (!resetn)
        $fell(step_trap_n) |-> $past(stepArm_q) && $past(fetchFall))
        else $error("step trap without a completed instruction");
    a_save_psw: assert property (@(posedge core_clk) disable iff (!resetn)
        !step_trap_n |-> !savedPsw_q[PSW_RUN_BIT] && savedPsw_q[PSW_STEP_BIT]
        && savedPc_q == $past(pcIn))
        else $error("saved status word wrong on step trap");
    a_rx_edge: assert property (@(posedge core_clk) disable iff (!resetn)
        rxEdge |=> status_q[ST_RX_EDGE])
        else $error("message edge not recorded in status");
    a_slot_first: assert property (@(posedge core_clk) disable iff (!resetn)
        rxStore_q |=> dataSlot_q[CODE_W-1:0] == $past(rxShift_q) ##1
        status_q[ST_RX_DONE])
        else $error("data slot not stored before completion");
    a_lock_hold: assert property (@(posedge core_clk) disable iff (!resetn)
        (initDone_q && !powerFail) |=> $stable(lock_q))
        else $error("lock sampled outside power events");
    a_tx_stack: assert property (@(posedge core_clk) disable iff (!resetn)
        txStart |=> stackPtr_q == STACK_INIT)
        else $error("stack pointer not loaded on transmit");
    a_run_send: assert property (@(posedge core_clk) disable iff (!resetn)
        (runMode && !runPrev_q) |-> ##[0:300] (txStart && txCode == RUN_CODE))
        else $error("run code not sent after entering run");
    c_rtc_taken: cover property (@(posedge core_clk) disable iff (!resetn)
        vectorTake && vectorAddr == VEC_RTC);
    c_step_trap: cover property (@(posedge core_clk) disable iff (!resetn)
        !step_trap_n);
    c_rx_char: cover property (@(posedge core_clk) disable iff (!resetn)
        rxDoneEv_q);
endmodule : hpi_panel_if

// ---- verif/hpi_panel_model.sv ----
`timescale 1ns/1ps
module hpi_panel_model (
    // panel lines
    input wire logic core_clk,
    output logic serialOut,
    output logic lockOut
);
    // line rests low, panel unlocked
    initial begin
        serialOut = 1'b0;
        lockOut = 1'b0;
    end
    // operator turns the lock switch
    task automatic setLock(input logic v);
        lockOut <= v;
    endtask : setLock
    // one frame: start high, inverted data lsb first, stops low
    task automatic send(input logic [6:0] code);
        logic [9:0] f;
        f = {2'b00, ~code, 1'b1};
        if (!lockOut) begin
            for (int i = 0; i < 10; i++) begin
                @(posedge core_clk);
                serialOut <= f[i];
                repeat (8) @(posedge core_clk);
            end
        end
    endtask : send
endmodule : hpi_panel_model

// ---- verif/handheld_panel_interface_tb_top.sv ----
`timescale 1ns/1ps
module handheld_panel_interface_tb_top import hpi_pkg::*; ();
    logic core_clk = 1'b0, resetn = 1'b0, regWr = 1'b0, regRd = 1'b0;
    logic [15:0] regAddr = 16'h0000, regWdata = 16'h0000;
    logic higherInService = 1'b0, instrEnd = 1'b0, fetch_phase_n = 1'b1;
    logic runMode = 1'b0, realtime_tick_n = 1'b1;
    logic powerFail = 1'b0, global_irq_enable = 1'b1;
    logic [9:0] frame;
    wire logic [15:0] regRdata, vectorAddr;
    wire logic level2_irq_n, panel_irq_n, vectorTake, step_flag_n;
    wire logic stepFlag, step_trap_n, firmware_irq, panelLock;
    wire logic panel_to_cpu_serial, cpu_to_panel_serial;
    int nErrors = 0, numChecks = 0, n;
    // 40 MHz clock
    always #12.5 core_clk = ~core_clk;
    hpi_panel_if i_hpi_panel_if (.core_clk, .resetn, .regAddr, .regWdata,
        .regWr, .regRd, .regRdata, .global_irq_enable,
        .higherInService, .instrEnd, .fetch_phase_n, .runMode,
        .powerFail, .pswIn(16'h0001), .pcIn(16'h1234), .level2_irq_n,
        .panel_irq_n, .vectorTake, .vectorAddr, .stepFlag, .step_flag_n,
        .step_trap_n, .firmware_irq, .rtc_enable_in(1'b1), .realtime_tick_n,
        .panel_to_cpu_serial, .panelLock, .cpu_to_panel_serial);
    hpi_panel_model i_hpi_panel_model (.core_clk,
        .serialOut(panel_to_cpu_serial), .lockOut(panelLock));
    task automatic summarize();
        $display("checks %0d errors %0d", numChecks, nErrors);
        if (nErrors == 0 && numChecks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        numChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tmo(input int k);
        if (k == 9) begin
            nErrors++;
            $display("[FAIL] %0t wait ran out", $time);
            summarize();
        end
    endtask : tmo
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 chk(regRdata, exp);
    endtask : rd
    // let one pending interrupt be taken and check its vector
    task automatic take(input logic [15:0] v);
        int k;
        instrEnd <= 1'b1;
        for (k = 0; k < 9 && vectorTake !== 1'b1; k++) @(negedge core_clk);
        instrEnd <= 1'b0;
        chk(vectorAddr, v);
        tmo(k);
    endtask : take
    // main sequence
    initial begin
        repeat (5) @(posedge core_clk);
        chk({15'h0, cpu_to_panel_serial}, 16'h0000);
        resetn <= 1'b1;
        rd(OFS_INCODE, 16'h0000);
        i_hpi_panel_model.setLock(1'b1);
        rd(OFS_INCODE, 16'h0000);
        powerFail <= 1'b1;
        @(posedge core_clk);
        powerFail <= 1'b0;
        rd(OFS_INCODE, 16'h0001);
        i_hpi_panel_model.setLock(1'b0);
        realtime_tick_n <= 1'b0;
        higherInService <= 1'b1;
        instrEnd <= 1'b1;
        repeat (6) @(posedge core_clk);
        #1 chk({15'h0, level2_irq_n}, 16'h0000);
        higherInService <= 1'b0;
        take(VEC_RTC);
        wr(OFS_PANEL_IRQ, 16'h0001);
        #1 chk({15'h0, panel_irq_n}, 16'h0000);
        global_irq_enable <= 1'b0;
        instrEnd <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1 chk({15'h0, panel_irq_n}, 16'h0000);
        global_irq_enable <= 1'b1;
        take(VEC_PANEL);
        rd(OFS_STATUS, 16'h0001);
        wr(OFS_STATUS, 16'h001f);
        wr(OFS_STEP_SET, 16'h0000);
        #1 chk({14'h0, stepFlag, step_flag_n}, 16'h0002);
        fetch_phase_n <= 1'b0;
        repeat (3) @(negedge core_clk);
        chk({15'h0, step_trap_n}, 16'h0001);
        fetch_phase_n <= 1'b1;
        repeat (3) @(negedge core_clk);
        fetch_phase_n <= 1'b0;
        for (n = 0; n < 9 && step_trap_n !== 1'b0; n++) @(negedge core_clk);
        tmo(n);
        rd(OFS_SAVE_PSW, 16'h0002);
        rd(OFS_SAVE_PC, 16'h1234);
        repeat (100) @(posedge core_clk);
        rd(OFS_STATUS, 16'h0018);
        wr(OFS_STATUS, 16'h001f);
        wr(OFS_TX_START, {9'h000, RUN_CODE});
        repeat (4) @(posedge core_clk);
        for (int i = 0; i < 10; i++) begin
            #1 frame[i] = cpu_to_panel_serial;
            repeat (9) @(posedge core_clk);
        end
        chk({6'h0, frame}, {8'h00, ~RUN_CODE, 1'b1});
        rd(OFS_STACK_PTR, STACK_INIT);
        rd(OFS_STATUS, 16'h0010);
        wr(OFS_MASK, 16'h0002);
        wr(OFS_STATUS, 16'h001f);
        i_hpi_panel_model.send(7'h49);
        repeat (20) @(posedge core_clk);
        #1 chk({15'h0, firmware_irq}, 16'h0001);
        rd(OFS_DATA_SLOT, 16'h0049);
        rd(OFS_STATUS, 16'h0006);
        wr(OFS_STATUS, 16'h001f);
        runMode <= 1'b1;
        for (n = 0; n < 9 && cpu_to_panel_serial !== 1'b1; n++)
            @(negedge core_clk);
        chk({15'h0, firmware_irq}, 16'h0000);
        tmo(n);
        summarize();
    end
endmodule : handheld_panel_interface_tb_top
